// ---- common/gio_port_map.vh ----
// Register map, field layout and reset values of the GPIO port
`ifndef GIO_PORT_MAP_VH
`define GIO_PORT_MAP_VH

// ----------------------------------------
// Port geometry
// ----------------------------------------
`define GIO_PINS          8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GIO_OFF_SAMPLE    12'h000
`define GIO_OFF_DIR       12'h004
`define GIO_OFF_VALUE     12'h008
`define GIO_OFF_CTRL      12'h00C
`define GIO_OFF_EXTEN     12'h010
`define GIO_OFF_EXTMODE   12'h014
`define GIO_OFF_STATUS    12'h018
`define GIO_OFF_MASK      12'h01C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define GIO_CTRL_PUD      0
`define GIO_CTRL_SLEEP    1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GIO_RST_BYTE      8'h00
`define GIO_RST_CTRL      2'h0
`define GIO_RST_OUTEN     8'hFF
`define GIO_RST_WORD      32'h00000000

`endif

// ---- hdl/gio_port.v ----
// One eight-pin general digital I/O port with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "gio_port_map.vh"

module gio_port (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Pads
  input  wire [7:0]  padIn,
  output reg  [7:0]  padOut,
  output reg  [7:0]  padOutEn_n,
  output reg  [7:0]  padPullUp,
  // Interrupt
  output reg         irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [7:0] pinDir;
  reg  [7:0] pinVal;
  reg  [7:0] syncLatch;
  reg  [7:0] pinSample;
  reg        pullupDisable;
  reg        sleepClamp;
  reg  [7:0] extEnable;
  reg  [7:0] extAnyEdge;
  reg  [7:0] status;
  reg  [7:0] mask;
  reg  [7:0] prevSample;
  reg  [1:0] ctrl;

  wire       wrEn = psel & penable & pwrite;
  wire       rdEn = psel & ~penable & ~pwrite;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function mapped;
    input [11:0] a;
    begin
      mapped = (a <= `GIO_OFF_MASK) && (a[1:0] == 2'h0);
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ----------------------------------------
  // Pin drive and pull-up
  // ----------------------------------------
  wire [7:0] next_padOutEn_n = ~pinDir;
  wire [7:0] next_padOut     = pinVal & pinDir;
  wire [7:0] next_padPullUp  = ~pinDir & pinVal & {8{~pullupDisable}};

  // Clamp to ground in deep sleep unless the external interrupt is enabled
  wire [7:0] schmitt = padIn & ~({8{sleepClamp}} & ~extEnable);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padOutEn_n <= `GIO_RST_OUTEN;
      padOut     <= `GIO_RST_BYTE;
      padPullUp  <= `GIO_RST_BYTE;
    end else begin
      padOutEn_n <= next_padOutEn_n;
      padOut     <= next_padOut;
      padPullUp  <= next_padPullUp;
    end
  end

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  // Falling-edge capture holds what the high-transparent latch holds
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncLatch <= `GIO_RST_BYTE;
    end else begin
      syncLatch <= schmitt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSample  <= `GIO_RST_BYTE;
      prevSample <= `GIO_RST_BYTE;
    end else begin
      pinSample  <= syncLatch;
      prevSample <= pinSample;
    end
  end

  // ----------------------------------------
  // Registers written by software
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinDir     <= `GIO_RST_BYTE;
      pinVal     <= `GIO_RST_BYTE;
      ctrl       <= `GIO_RST_CTRL;
      extEnable  <= `GIO_RST_BYTE;
      extAnyEdge <= `GIO_RST_BYTE;
      mask       <= `GIO_RST_BYTE;
    end else if (wrEn) begin
      if (hit(paddr, `GIO_OFF_SAMPLE)) begin
        pinVal <= pinVal ^ pwdata[7:0];
      end else if (hit(paddr, `GIO_OFF_DIR)) begin
        pinDir <= pwdata[7:0];
      end else if (hit(paddr, `GIO_OFF_VALUE)) begin
        pinVal <= pwdata[7:0];
      end else if (hit(paddr, `GIO_OFF_CTRL)) begin
        ctrl <= pwdata[1:0];
      end else if (hit(paddr, `GIO_OFF_EXTEN)) begin
        extEnable <= pwdata[7:0];
      end else if (hit(paddr, `GIO_OFF_EXTMODE)) begin
        extAnyEdge <= pwdata[7:0];
      end else if (hit(paddr, `GIO_OFF_MASK)) begin
        mask <= pwdata[7:0];
      end
    end
  end

  always @* begin
    pullupDisable = ctrl[`GIO_CTRL_PUD];
    sleepClamp    = ctrl[`GIO_CTRL_SLEEP];
  end

  // ----------------------------------------
  // External interrupt flags
  // ----------------------------------------
  // Edge pins flag any change of the sampled level, so releasing the clamp
  // on a high pin sets the flag even while the interrupt is disabled
  wire [7:0] pinEdge = (pinSample ^ prevSample) & extAnyEdge;
  wire [7:0] wrClr   = (wrEn && hit(paddr, `GIO_OFF_STATUS)) ? pwdata[7:0] : 8'h00;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `GIO_RST_BYTE;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~wrClr) | pinEdge;
      irq    <= |(((status & ~wrClr) | pinEdge) & mask);
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= `GIO_RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (rdEn) begin
        if (hit(paddr, `GIO_OFF_SAMPLE)) begin
          prdata <= {24'h000000, pinSample};
        end else if (hit(paddr, `GIO_OFF_DIR)) begin
          prdata <= {24'h000000, pinDir};
        end else if (hit(paddr, `GIO_OFF_VALUE)) begin
          prdata <= {24'h000000, pinVal};
        end else if (hit(paddr, `GIO_OFF_CTRL)) begin
          prdata <= {30'h00000000, ctrl};
        end else if (hit(paddr, `GIO_OFF_EXTEN)) begin
          prdata <= {24'h000000, extEnable};
        end else if (hit(paddr, `GIO_OFF_EXTMODE)) begin
          prdata <= {24'h000000, extAnyEdge};
        end else if (hit(paddr, `GIO_OFF_STATUS)) begin
          prdata <= {24'h000000, status};
        end else if (hit(paddr, `GIO_OFF_MASK)) begin
          prdata <= {24'h000000, mask};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- test/gio_port_props.sv ----
// Checker of bus and pad relations of the port
`timescale 1ns/1ps
`default_nettype none
`include "gio_port_map.vh"
module gio_port_props (
  // Clock, reset and APB
  input wire logic        clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Pads
  input wire logic [7:0]  padOut, padOutEn_n, padPullUp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire setup = psel && !penable;
  ready_setup_a: assert property (setup |=> pready)
    else $error("ready missing");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_unmapped_a: assert property (setup && paddr > 12'h01C |=> pslverr)
    else $error("error missing");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  reset_tristate_a: assert property (disable iff (1'b0) !rst_n |-> padOutEn_n == 8'hFF && padPullUp == 8'h00)
    else $error("pins active in reset");
  pull_input_a: assert property ((padPullUp & ~padOutEn_n) == 8'h00)
    else $error("pull-up on output");
  drive_gate_a: assert property ((padOut & padOutEn_n) == 8'h00)
    else $error("level on released pin");
  dir_write_a: assert property (pready && pwrite && paddr == `GIO_OFF_DIR |-> ##2 padOutEn_n == ~$past(pwdata[7:0], 2))
    else $error("direction not applied");
endmodule
bind gio_port gio_port_props i_props (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .padOut(padOut), .padOutEn_n(padOutEn_n), .padPullUp(padPullUp));
`default_nettype wire

// ---- test/gio_pad_model.sv ----
// Pad model that resolves each pin level
`timescale 1ns/1ps
`default_nettype none
module gio_pad_model (
  // Port and board side
  input  wire logic       clk,
  input  wire logic [7:0] padOut, padOutEn_n, padPullUp, extVal, extEn,
  // Pin levels
  output var  logic [7:0] padIn
);
  logic [7:0] flo = 8'h55;
  always @(posedge clk) flo <= ~flo;
  // Driver wins, then board, then pull-up, else a floating pattern
  assign padIn = ~padOutEn_n & padOut
    | padOutEn_n & (extEn & extVal | ~extEn & (padPullUp | flo));
endmodule
`default_nettype wire

// ---- test/gio_port_bench.sv ----
// Self-checking bench of the GPIO port
`timescale 1ns/1ps
`default_nettype none
`include "gio_port_map.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin badCount++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module gio_port_bench;
  logic        clk = 1'b0, rst_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, irq, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  padIn, padOut, padOutEn_n, padPullUp, extVal = 8'h0, extEn = 8'hFF;
  int          badCount = 0, comparisons = 0;
  gio_port i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .padIn(padIn), .padOut(padOut), .padOutEn_n(padOutEn_n), .padPullUp(padPullUp), .irq(irq));
  gio_pad_model i_pads (.clk(clk), .padOut(padOut), .padOutEn_n(padOutEn_n),
    .padPullUp(padPullUp), .extVal(extVal), .extEn(extEn), .padIn(padIn));
  initial forever #2 clk = ~clk;
  initial begin
    #20000 badCount++;
    conclude();
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) badCount++;
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic t_pins;
    rdchk(`GIO_OFF_DIR, 8'h00);
    extEn <= 8'h00;
    wr(`GIO_OFF_VALUE, 8'hF3);
    cyc(3);
    `CHK(padPullUp, 8'hF3)
    apb(1'b0, `GIO_OFF_SAMPLE, 32'h0);
    `CHK(rd[7:0] & 8'hF3, 8'hF3)
    wr(`GIO_OFF_CTRL, 8'h01);
    cyc(2);
    `CHK(padPullUp, 8'h00)
    wr(`GIO_OFF_CTRL, 8'h00);
    extEn <= 8'hFF;
    wr(`GIO_OFF_DIR, 8'h0F);
    cyc(3);
    `CHK({padOutEn_n, padOut, padPullUp}, 24'hF003F0)
    rdchk(`GIO_OFF_SAMPLE, 8'h03);
    wr(`GIO_OFF_SAMPLE, 8'h81);
    rdchk(`GIO_OFF_VALUE, 8'h72);
    rst_n <= 1'b0;
    cyc(1);
    `CHK({padOutEn_n, padPullUp}, 16'hFF00)
    rst_n <= 1'b1;
    $display("pins test done");
  endtask
  task automatic t_sleep;
    extVal <= 8'hF0;
    rdchk(`GIO_OFF_SAMPLE, 8'hF0);
    wr(`GIO_OFF_EXTEN, 8'h80);
    wr(`GIO_OFF_EXTMODE, 8'hC0);
    wr(`GIO_OFF_DIR, 8'h03);
    wr(`GIO_OFF_VALUE, 8'h03);
    wr(`GIO_OFF_CTRL, 8'h02);
    cyc(3);
    rdchk(`GIO_OFF_SAMPLE, 8'h80);
    wr(`GIO_OFF_STATUS, 8'hFF);
    wr(`GIO_OFF_CTRL, 8'h00);
    cyc(3);
    rdchk(`GIO_OFF_STATUS, 8'h40);
    $display("sleep test done");
  endtask
  task automatic t_irq;
    wr(`GIO_OFF_MASK, 8'h80);
    extVal <= 8'h70;
    cyc(4);
    `CHK(irq, 1'b1)
    rdchk(`GIO_OFF_STATUS, 8'hC0);
    wr(`GIO_OFF_MASK, 8'h00);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(`GIO_OFF_STATUS, 8'hFF);
    rdchk(`GIO_OFF_STATUS, 8'h00);
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("irq test done");
  endtask
  task automatic conclude;
    $display("Counts: %0d compared, %0d bad", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    t_pins();
    t_sleep();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
